// ===== dsq_top.sv
// register file, voltage decode and rail delay sequencing of the dual rail converter
//
// Operation
// RULE_01: negative target is 9-bit code, 15mV steps
// RULE_02: msb from 0x31 bit0, low byte 0x32
// RULE_03: host writes msb register before low byte
// RULE_04: all nine bits apply on low byte write
// RULE_05: low and high voltage range spans
// RULE_06: codes to 0x02D floor, then one step each
// RULE_07: 0x40[7:4] negative start-up delay
// RULE_08: 0x40[3:0] negative power-down delay
// RULE_09: 0x41[7:4] positive start-up delay
// RULE_10: 0x41[3:0] positive power-down delay
// RULE_11: 0x30 bit6 selects voltage range
// RULE_12: reset loads factory values, host overrides
// RULE_13: delays counted in 0.2ms ticks from edge
module dsq_top #(
	parameter int TICK_CYCLES = dsq_pkg::TICK_CYCLES,
	parameter int TICK_W      = 14
)(
	input  wire logic                 clock,
	input  wire logic                 nrst,
	input  wire dsq_pkg::dsq_reg_req_s reg_req,
	output logic [7:0]                reg_rdata_ff,
	input  wire logic [8:0]           otp_target_code,
	input  wire logic                 otp_range_select,
	input  wire logic [7:0]           otp_neg_delays,
	input  wire logic [7:0]           otp_pos_delays,
	input  wire logic                 rail_enable,
	output logic [8:0]                neg_rail_target_code_ff,
	output logic                      neg_rail_range_select_ff,
	output logic [15:0]               neg_rail_mv_ff,
	output logic                      otp_loaded_ff,
	output logic                      neg_rail_on_ff,
	output logic                      pos_rail_on_ff
);
	logic       msb_stage_ff;
	logic [2:0] msb_rsvd_ff;
	logic [7:0] neg_dly_ff;
	logic [7:0] pos_dly_ff;
	logic       nxt_msb_stage;
	logic [2:0] nxt_msb_rsvd;
	logic [7:0] nxt_neg_dly;
	logic [7:0] nxt_pos_dly;
	logic [8:0] nxt_code;
	logic       nxt_range;
	logic       nxt_loaded;
	logic [7:0] nxt_rdata;
	logic [15:0] nxt_mv;
	logic [15:0] base_mv;
	logic        wr_ok;

	// register writes, factory load and read data
	always_comb
	begin
		nxt_msb_stage = msb_stage_ff;
		nxt_msb_rsvd = msb_rsvd_ff;
		nxt_neg_dly = neg_dly_ff;
		nxt_pos_dly = pos_dly_ff;
		nxt_code = neg_rail_target_code_ff;
		nxt_range = neg_rail_range_select_ff;
		nxt_loaded = 1'b1;
		wr_ok = reg_req.wr && otp_loaded_ff;
		if (!otp_loaded_ff)
		begin
			nxt_code = otp_target_code; // RULE_12
			nxt_msb_stage = otp_target_code[8];
			nxt_range = otp_range_select;
			nxt_neg_dly = otp_neg_delays;
			nxt_pos_dly = otp_pos_delays;
		end
		if (wr_ok)
		begin
			unique case (reg_req.addr)
				dsq_pkg::ADDR_RANGE:
					nxt_range = reg_req.wdata[dsq_pkg::RANGE_BIT]; // RULE_11
				dsq_pkg::ADDR_TGT_MSB:
				begin
					// only staged here; the live code waits for the low byte
					nxt_msb_stage = reg_req.wdata[dsq_pkg::MSB_BIT]; // RULE_02
					nxt_msb_rsvd = reg_req.wdata[3:1];
				end
				dsq_pkg::ADDR_TGT_LOW:
					nxt_code = {msb_stage_ff, reg_req.wdata}; // RULE_04
				dsq_pkg::ADDR_NEG_DLY:
					nxt_neg_dly = reg_req.wdata; // RULE_07 RULE_08
				dsq_pkg::ADDR_POS_DLY:
					nxt_pos_dly = reg_req.wdata; // RULE_09 RULE_10
				default:
					nxt_loaded = 1'b1;
			endcase
		end
		nxt_rdata = dsq_pkg::RDATA_RST;
		if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				dsq_pkg::ADDR_RANGE:
					nxt_rdata[dsq_pkg::RANGE_BIT] = neg_rail_range_select_ff;
				dsq_pkg::ADDR_TGT_MSB:
					nxt_rdata = {4'h0, msb_rsvd_ff, msb_stage_ff};
				dsq_pkg::ADDR_TGT_LOW:
					nxt_rdata = neg_rail_target_code_ff[7:0];
				dsq_pkg::ADDR_NEG_DLY:
					nxt_rdata = neg_dly_ff;
				dsq_pkg::ADDR_POS_DLY:
					nxt_rdata = pos_dly_ff;
				default:
					nxt_rdata = dsq_pkg::RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			msb_stage_ff <= 1'b0;
			msb_rsvd_ff <= 3'h0;
			neg_dly_ff <= {dsq_pkg::DLY_RST, dsq_pkg::DLY_RST};
			pos_dly_ff <= {dsq_pkg::DLY_RST, dsq_pkg::DLY_RST};
			neg_rail_target_code_ff <= dsq_pkg::CODE_RST;
			neg_rail_range_select_ff <= 1'b0;
			otp_loaded_ff <= 1'b0;
			reg_rdata_ff <= dsq_pkg::RDATA_RST;
		end
		else
		begin
			msb_stage_ff <= nxt_msb_stage;
			msb_rsvd_ff <= nxt_msb_rsvd;
			neg_dly_ff <= nxt_neg_dly;
			pos_dly_ff <= nxt_pos_dly;
			neg_rail_target_code_ff <= nxt_code;
			neg_rail_range_select_ff <= nxt_range;
			otp_loaded_ff <= nxt_loaded;
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// target magnitude in millivolts from code and range
	always_comb
	begin
		base_mv = neg_rail_range_select_ff ? dsq_pkg::HIGH_BASE_MV
			: dsq_pkg::LOW_BASE_MV; // RULE_05 RULE_11
		if (neg_rail_target_code_ff <= dsq_pkg::CODE_FLOOR)
			nxt_mv = base_mv; // RULE_06
		else
			nxt_mv = base_mv + 16'(dsq_pkg::STEP_MV
				* 16'(neg_rail_target_code_ff - dsq_pkg::CODE_FLOOR)); // RULE_01
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			neg_rail_mv_ff <= dsq_pkg::LOW_BASE_MV;
		else
			neg_rail_mv_ff <= nxt_mv;
	end

	// timers stay off until the factory values are in place
	logic        en_q;
	logic [7:0]  dly [2];
	logic [1:0]  on_q;
	assign en_q = rail_enable && otp_loaded_ff;
	assign dly[0] = neg_dly_ff;
	assign dly[1] = pos_dly_ff;

	for (genvar g = 0; g < 2; g++)
	begin : g_rail
		dsq_rail_timer #(
			.TICK_CYCLES (TICK_CYCLES),
			.TICK_W      (TICK_W)
		) u_timer (
			.clock          (clock),
			.nrst           (nrst),
			.rail_enable    (en_q),
			.startup_code   (dly[g][dsq_pkg::STARTUP_HI:dsq_pkg::STARTUP_LO]),
			.powerdown_code (dly[g][dsq_pkg::POWERDOWN_HI:dsq_pkg::POWERDOWN_LO]),
			.rail_on_ff     (on_q[g])
		);
	end

	assign neg_rail_on_ff = on_q[0];
	assign pos_rail_on_ff = on_q[1];

	a_low_write_apply: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
		reg_req.wr && otp_loaded_ff && reg_req.addr == dsq_pkg::ADDR_TGT_LOW
		|=> neg_rail_target_code_ff == {$past(msb_stage_ff), $past(reg_req.wdata)})
		else $error("low byte write did not apply nine bits");
	a_msb_write_stage: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
		reg_req.wr && otp_loaded_ff && reg_req.addr == dsq_pkg::ADDR_TGT_MSB
		|=> $stable(neg_rail_target_code_ff) && msb_stage_ff == $past(reg_req.wdata[0]))
		else $error("msb write changed live code or was not staged");
	a_msb_read_back: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
		reg_req.rd && reg_req.addr == dsq_pkg::ADDR_TGT_MSB
		|=> reg_rdata_ff[0] == $past(msb_stage_ff) && reg_rdata_ff[7:4] == 4'h0)
		else $error("msb read back wrong");
	a_floor_codes: assert property (@(posedge clock) disable iff (!nrst) // RULE_06
		neg_rail_target_code_ff <= 9'h02d && !neg_rail_range_select_ff
		|=> neg_rail_mv_ff == 16'd17010)
		else $error("floor code magnitude wrong");
	a_step_size: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
		neg_rail_target_code_ff == 9'h06f && neg_rail_range_select_ff
		|=> neg_rail_mv_ff == 16'd11000)
		else $error("step of 15 mV not kept");
	a_top_code: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
		neg_rail_target_code_ff == 9'h1ff ##1 neg_rail_target_code_ff == 9'h1ff
		|-> neg_rail_mv_ff == ($past(neg_rail_range_select_ff) ? 16'd17000 : 16'd24000))
		else $error("top code magnitude wrong");
	a_delay_write: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
		reg_req.wr && otp_loaded_ff && reg_req.addr == dsq_pkg::ADDR_NEG_DLY
		|=> neg_dly_ff == $past(reg_req.wdata))
		else $error("delay register not written");
	a_otp_load: assert property (@(posedge clock) disable iff (!nrst) // RULE_12
		$rose(otp_loaded_ff) |-> neg_rail_target_code_ff == $past(otp_target_code)
			&& pos_dly_ff == $past(otp_pos_delays))
		else $error("factory values not loaded");
	c_nine_bit_write: cover property (@(posedge clock) disable iff (!nrst)
		reg_req.wr && reg_req.addr == dsq_pkg::ADDR_TGT_MSB ##[1:4]
		reg_req.wr && reg_req.addr == dsq_pkg::ADDR_TGT_LOW);
	c_high_range: cover property (@(posedge clock) disable iff (!nrst)
		$rose(neg_rail_range_select_ff));
	c_both_on: cover property (@(posedge clock) disable iff (!nrst)
		neg_rail_on_ff && pos_rail_on_ff);
endmodule

// ===== dsq_pkg.sv
// shared constants, types and register map of the dual rail sequencer configuration
package dsq_pkg;
	localparam logic [7:0]  ADDR_RANGE      = 8'h30;
	localparam logic [7:0]  ADDR_TGT_MSB    = 8'h31;
	localparam logic [7:0]  ADDR_TGT_LOW    = 8'h32;
	localparam logic [7:0]  ADDR_NEG_DLY    = 8'h40;
	localparam logic [7:0]  ADDR_POS_DLY    = 8'h41;
	localparam int          RANGE_BIT       = 6;
	localparam int          MSB_BIT         = 0;
	localparam int          STARTUP_HI      = 7;
	localparam int          STARTUP_LO      = 4;
	localparam int          POWERDOWN_HI    = 3;
	localparam int          POWERDOWN_LO    = 0;
	localparam int          CODE_W          = 9;
	localparam logic [8:0]  CODE_FLOOR      = 9'h02d;
	localparam logic [15:0] STEP_MV         = 16'h000f;
	localparam logic [15:0] LOW_BASE_MV     = 16'h4272;
	localparam logic [15:0] HIGH_BASE_MV    = 16'h271a;
	localparam logic [7:0]  RDATA_RST       = 8'h00;
	localparam logic [8:0]  CODE_RST        = 9'h000;
	localparam logic [3:0]  DLY_RST         = 4'h0;
	localparam int          TICK_US         = 200;
	localparam int          CLK_PERIOD_NS   = 20;
	localparam int          TICK_CYCLES     = (TICK_US * 1000) / CLK_PERIOD_NS;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dsq_reg_req_s;

	typedef enum logic [1:0]
	{
		ST_OFF     = 2'b00,
		ST_RAMP_UP = 2'b01,
		ST_ON      = 2'b11,
		ST_RAMP_DN = 2'b10
	} dsq_rail_state_e;
endpackage

// ===== dsq_rail_timer.sv
// start-up and power-down delay timer for one rail
module dsq_rail_timer #(
	parameter int TICK_CYCLES = dsq_pkg::TICK_CYCLES,
	parameter int TICK_W      = 14
)(
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       rail_enable,
	input  wire logic [3:0] startup_code,
	input  wire logic [3:0] powerdown_code,
	output logic            rail_on_ff
);
	dsq_pkg::dsq_rail_state_e state_ff;
	dsq_pkg::dsq_rail_state_e nxt_state;
	logic [TICK_W-1:0]        pre_ff;
	logic [TICK_W-1:0]        nxt_pre;
	logic [4:0]               left_ff;
	logic [4:0]               nxt_left;
	logic                     en_ff;
	logic                     nxt_rail_on;
	logic                     en_edge;

	always_comb
	begin
		en_edge = rail_enable ^ en_ff;
		nxt_state = state_ff;
		nxt_pre = pre_ff;
		nxt_left = left_ff;
		if (en_edge)
		begin
			// prescaler restarts on the edge so every delay is exact
			nxt_state = rail_enable ? dsq_pkg::ST_RAMP_UP : dsq_pkg::ST_RAMP_DN; // RULE_13
			nxt_pre = '0;
			nxt_left = {1'b0, rail_enable ? startup_code : powerdown_code} + 5'h01; // RULE_07
		end
		else if (state_ff == dsq_pkg::ST_RAMP_UP || state_ff == dsq_pkg::ST_RAMP_DN)
		begin
			if (pre_ff == TICK_W'(TICK_CYCLES - 1))
			begin
				nxt_pre = '0; // RULE_13
				nxt_left = left_ff - 5'h01;
				if (left_ff == 5'h01)
					nxt_state = (state_ff == dsq_pkg::ST_RAMP_UP) ? dsq_pkg::ST_ON
						: dsq_pkg::ST_OFF; // RULE_08
			end
			else
				nxt_pre = pre_ff + TICK_W'(1);
		end
		// the rail keeps its level while a delay runs and changes only when it ends
		nxt_rail_on = rail_on_ff;
		if (nxt_state == dsq_pkg::ST_ON)
			nxt_rail_on = 1'b1;
		else if (nxt_state == dsq_pkg::ST_OFF)
			nxt_rail_on = 1'b0; // RULE_08 RULE_10
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= dsq_pkg::ST_OFF;
			pre_ff <= '0;
			left_ff <= 5'h00;
			en_ff <= 1'b0;
			rail_on_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			pre_ff <= nxt_pre;
			left_ff <= nxt_left;
			en_ff <= rail_enable;
			rail_on_ff <= nxt_rail_on;
		end
	end

	// helper: cycles since the last enable edge and the delay code caught then
	int   wait_cnt;
	logic [3:0] code_cap;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			wait_cnt <= 0;
			code_cap <= 4'h0;
		end
		else if (en_edge)
		begin
			wait_cnt <= 1;
			code_cap <= rail_enable ? startup_code : powerdown_code;
		end
		else
			wait_cnt <= wait_cnt + 1;
	end

	a_startup_length: assert property (@(posedge clock) disable iff (!nrst) // RULE_09
		$rose(rail_on_ff) |-> wait_cnt == (int'(code_cap) + 1) * TICK_CYCLES + 1)
		else $error("start-up delay length wrong");
	a_powerdown_length: assert property (@(posedge clock) disable iff (!nrst) // RULE_10
		$fell(rail_on_ff) |-> wait_cnt == (int'(code_cap) + 1) * TICK_CYCLES + 1)
		else $error("power-down delay length wrong");
	a_edge_starts_wait: assert property (@(posedge clock) disable iff (!nrst) // RULE_13
		en_edge |=> (state_ff == dsq_pkg::ST_RAMP_UP || state_ff == dsq_pkg::ST_RAMP_DN)
			&& pre_ff == '0)
		else $error("enable edge did not start a delay");
	c_rail_up: cover property (@(posedge clock) disable iff (!nrst) $rose(rail_on_ff));
	c_rail_down: cover property (@(posedge clock) disable iff (!nrst) $fell(rail_on_ff));
endmodule

// ===== dsq_host_model.sv
// host side model issuing decoded register requests on the falling clock edge
module dsq_host_model (
	input  wire logic             clock,
	output dsq_pkg::dsq_reg_req_s reg_req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial reg_req = '0;

	// held for exactly one rising edge, so each call is sampled once; back-to-back calls keep wr or rd high
	task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		reg_req <= '{wr: w, rd: r, addr: a, wdata: d};
		@(negedge clock);
	endtask

	task automatic idle();
		reg_req <= '0;
		@(negedge clock);
	endtask

	// nine bit update: staged msb first, low byte second
	task automatic set_code(input logic [8:0] c);
		xfer(1'b1, 1'b0, 8'h31, {7'h00, c[8]});
		xfer(1'b1, 1'b0, 8'h32, c[7:0]);
		idle();
	endtask
endmodule

// ===== tb_top.sv
// self-checking bench of the dual rail sequencer configuration
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TCK = 4;
	logic                  clock = 1'b0;
	logic                  nrst = 1'b0;
	logic                  rail_enable = 1'b0;
	logic [8:0]            otp_code = 9'h000;
	logic                  otp_rng = 1'b0;
	logic [7:0]            otp_nd = 8'h00;
	logic [7:0]            otp_pd = 8'h00;
	dsq_pkg::dsq_reg_req_s reg_req;
	logic [7:0]            rdata;
	logic [8:0]            code_ff;
	logic                  range_ff;
	logic [15:0]           mv_ff;
	logic                  loaded_ff;
	logic [1:0]            on_ff;
	logic [7:0]            exp_q[$];
	logic [7:0]            exp_r;
	logic                  rd_seen = 1'b0;
	int                    num_errors = 0;
	int                    checks_done = 0;
	time                   t_up[2];
	time                   t_dn[2];
	logic [8:0]            codes[6] = '{9'h000, 9'h02d, 9'h02e, 9'h06f, 9'h1fe, 9'h1ff};

	dsq_host_model u_dsq_host_model (.clock(clock), .reg_req(reg_req));

	dsq_top #(.TICK_CYCLES(TCK)) u_dsq_top (
		.clock(clock), .nrst(nrst), .reg_req(reg_req), .reg_rdata_ff(rdata),
		.otp_target_code(otp_code), .otp_range_select(otp_rng),
		.otp_neg_delays(otp_nd), .otp_pos_delays(otp_pd), .rail_enable(rail_enable),
		.neg_rail_target_code_ff(code_ff), .neg_rail_range_select_ff(range_ff),
		.neg_rail_mv_ff(mv_ff), .otp_loaded_ff(loaded_ff),
		.neg_rail_on_ff(on_ff[0]), .pos_rail_on_ff(on_ff[1])
	);

	always #10 clock = ~clock;
	always @(posedge on_ff[0]) t_up[0] = $time;
	always @(posedge on_ff[1]) t_up[1] = $time;
	always @(negedge on_ff[0]) t_dn[0] = $time;
	always @(negedge on_ff[1]) t_dn[1] = $time;
	always @(posedge clock) rd_seen <= reg_req.rd;

	// read data stands one cycle after the request edge
	always @(negedge clock)
	begin
		if (rd_seen)
		begin
			exp_r = exp_q.pop_front();
			`CHK(rdata, exp_r)
		end
	end

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_dsq_host_model.xfer(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_dsq_host_model.xfer(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic chk_code(input logic [8:0] c, input logic r);
		logic [15:0] mv;
		mv = (r ? 16'h271a : 16'h4272) + ((c > 9'h02d) ? 16'h000f * 16'(c - 9'h02d) : 16'h0000);
		`CHK(code_ff, c)
		`CHK(mv_ff, mv)
	endtask

	function automatic time dly(input logic [3:0] c);
		return 10 + 20 * (c + 1) * TCK;
	endfunction

	// rise and fall measured from the enable change to the rail output edge
	task automatic rails(input logic [7:0] nd, input logic [7:0] pd);
		time t0;
		wr(8'h40, nd);
		wr(8'h41, pd);
		rd(8'h40, nd);
		rd(8'h41, pd);
		u_dsq_host_model.idle();
		rail_enable <= 1'b1;
		t0 = $time;
		repeat (70) @(negedge clock);
		`CHK(t_up[0] - t0, dly(nd[7:4]))
		`CHK(t_up[1] - t0, dly(pd[7:4]))
		`CHK(on_ff, 2'b11)
		rail_enable <= 1'b0;
		t0 = $time;
		repeat (70) @(negedge clock);
		`CHK(t_dn[0] - t0, dly(nd[3:0]))
		`CHK(t_dn[1] - t0, dly(pd[3:0]))
		`CHK(on_ff, 2'b00)
	endtask

	initial
	begin
		#1_000_000;
		num_errors++;
		final_report();
	end

	initial
	begin
		logic [8:0] c;
		void'($urandom(32'h058e));
		otp_code = 9'($urandom);
		otp_rng = 1'($urandom);
		otp_nd = 8'($urandom);
		otp_pd = 8'($urandom);
		repeat (2) @(negedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		`CHK(loaded_ff, 1'b1)
		`CHK(code_ff, otp_code)
		`CHK(range_ff, otp_rng)
		rd(8'h31, {7'h00, otp_code[8]});
		rd(8'h32, otp_code[7:0]);
		rd(8'h30, {1'b0, otp_rng, 6'h00});
		rd(8'h40, otp_nd);
		rd(8'h41, otp_pd);
		rd(8'h33, 8'h00);
		wr(8'h30, 8'hff);
		wr(8'h31, 8'hff);
		rd(8'h30, 8'h40);
		rd(8'h31, 8'h0f);
		wr(8'h31, 8'h00);
		u_dsq_host_model.idle();
		chk_code(otp_code, 1'b1);
		for (int r = 0; r < 2; r++)
		begin
			wr(8'h30, {1'b0, r[0], 6'h00});
			foreach (codes[i])
			begin
				u_dsq_host_model.set_code(codes[i]);
				chk_code(codes[i], r[0]);
			end
		end
		wr(8'h32, 8'h00);
		u_dsq_host_model.idle();
		u_dsq_host_model.idle();
		chk_code(9'h100, 1'b1);
		repeat (4)
		begin
			c = 9'($urandom);
			u_dsq_host_model.set_code(c);
			chk_code(c, 1'b1);
		end
		rails(8'h0f, 8'hf0);
		repeat (2) rails(8'($urandom), 8'($urandom));
		final_report();
	end
endmodule
